// ===== core/evt_ic_defs.vh
// Shared constants for the event channel interconnect
`ifndef EVT_IC_DEFS_VH
`define EVT_IC_DEFS_VH

// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define NUM_CH       16
`define NUM_GRP      6
`define NUM_GSUB     12
`define NUM_EVT      8
`define NUM_TSK      8
`define IDX_W        8
`define CH_SEL_W     4
`define CFG_W        9
`define ADDR_W       12

// ----------------------------------------------------------------
// Field positions of a publish or subscribe setting and of a group task word
// ----------------------------------------------------------------
`define CFG_EN_BIT   31
`define CFG_EN_LOC   8
`define TASK_GO_BIT  0

// ----------------------------------------------------------------
// Register offsets and window sizes
// ----------------------------------------------------------------
`define OFS_GRP_TASK 12'h000
`define SPAN_GRP     12'h030
`define OFS_GRP_SUB  12'h080
`define OFS_CHANNEL_ENABLE_REG     12'h500
`define OFS_CHANNEL_ENABLE_REG_SET 12'h504
`define OFS_CHANNEL_ENABLE_REG_CLR 12'h508
`define OFS_CHG      12'h800
`define SPAN_CHG     12'h018
`define OFS_PUB      12'h900
`define SPAN_PUB     12'h020
`define OFS_TSUB     12'ha00
`define SPAN_TSUB    12'h020

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_CHANNEL_ENABLE_REG     16'h0000
`define RST_CHG      16'h0000
`define RST_CFG      9'h000
`define RST_RDATA    32'h0000_0000

`endif

// ===== core/evt_publish.v
// Merges published event pulses onto channel lines
`timescale 1ns/1ps
`include "evt_ic_defs.vh"

module evt_publish (
	input  wire [`NUM_EVT-1:0]        evt_in,
	input  wire [`NUM_EVT*`CFG_W-1:0] pub_cfg,
	output wire [`NUM_CH-1:0]         chan_raw
);

	genvar gc;

	// ------------------------------------------------------------
	// One OR tree per channel
	// ------------------------------------------------------------
	generate
		for (gc = 0; gc < `NUM_CH; gc = gc + 1) begin : g_ch
			localparam integer CH = gc;
			reg merged;
			integer e;
			// Any enabled event aimed here drives the channel
			always @* begin
				merged = 1'h0;
				for (e = 0; e < `NUM_EVT; e = e + 1) begin
					if (pub_cfg[e*`CFG_W+`CFG_EN_LOC] &&
					    pub_cfg[e*`CFG_W +: `IDX_W] == CH)
						merged = merged | evt_in[e];
				end
			end
			assign chan_raw[gc] = merged;
		end
	endgenerate

endmodule

// ===== core/task_subscribe.v
// Picks each task's trigger from the channel its setting selects
`timescale 1ns/1ps
`include "evt_ic_defs.vh"

module task_subscribe #(
	parameter NT = 8
) (
	input  wire [`NUM_CH-1:0]    chan,
	input  wire [NT*`CFG_W-1:0]  sub_cfg,
	output wire [NT-1:0]         hit
);

	genvar gt;

	// ------------------------------------------------------------
	// One selector per task
	// ------------------------------------------------------------
	generate
		for (gt = 0; gt < NT; gt = gt + 1) begin : g_tsk
			wire [`IDX_W-1:0] idx;
			wire              en;
			assign idx = sub_cfg[gt*`CFG_W +: `IDX_W];
			assign en  = sub_cfg[gt*`CFG_W+`CFG_EN_LOC];
			// Indices beyond the last channel select nothing
			assign hit[gt] = en && (idx < `NUM_CH) &&
			                 chan[idx[`CH_SEL_W-1:0]];
		end
	endgenerate

endmodule

// ===== core/evt_interconnect.v
// Event channel interconnect: channel config unit and local routing
//
// The address map and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`include "evt_ic_defs.vh"

// Overview of operation
// - Each event and task has own setting
// - Setting holds channel index field
// - Connection acts only while enable set
// - Channel pulse triggers all subscribed tasks
// - Published event fires subscribed task on enabled channel
// - Simultaneous events merge into one pulse
// - Global enable central, connection local
// - Channel enable, set, clear registers
// - Group tasks enable or disable members
// - Enable wins over disable same cycle
// - Group tasks have own subscribe settings
// - Group write dropped while subscribed
// - Self-disabling group gives one-shot routing
// - Index low eight bits, enable top bit
// - Set and clear read channel enables
module evt_interconnect (
	input  wire                sys_clk,
	input  wire                rst,
	input  wire [`ADDR_W-1:0]  addr,
	input  wire [31:0]         wdata,
	input  wire                wr,
	input  wire                rd,
	output wire [31:0]         rdata,
	input  wire [`NUM_EVT-1:0] evt_in,
	output wire [`NUM_TSK-1:0] task_out,
	output wire [`NUM_CH-1:0]  chan_pulse
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	reg  [`NUM_CH-1:0]  channel_enable_reg_q;
	reg  [`NUM_CH-1:0]  channel_enable_reg_d;
	reg  [`NUM_CH-1:0]  channel_group_members_q [0:`NUM_GRP-1];
	reg  [`CFG_W-1:0]   pub_q  [0:`NUM_EVT-1];
	reg  [`CFG_W-1:0]   tsub_q [0:`NUM_TSK-1];
	reg  [`CFG_W-1:0]   gsub_q [0:`NUM_GSUB-1];
	reg  [31:0]         rdata_q;
	reg  [31:0]         rdata_d;
	reg  [`NUM_TSK-1:0] task_q;
	reg  [`NUM_CH-1:0]  chan_pulse_q;

	wire [`NUM_EVT*`CFG_W-1:0]  pub_flat;
	wire [`NUM_TSK*`CFG_W-1:0]  tsub_flat;
	wire [`NUM_GSUB*`CFG_W-1:0] gsub_flat;
	wire [`NUM_CH-1:0]          chan_raw;
	wire [`NUM_CH-1:0]          chan_live;
	wire [`NUM_TSK-1:0]         tsub_hit;
	wire [`NUM_GSUB-1:0]        gsub_hit;

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	wire [`ADDR_W-1:0] off_gt;
	wire [`ADDR_W-1:0] off_gs;
	wire [`ADDR_W-1:0] off_chg;
	wire [`ADDR_W-1:0] off_pub;
	wire [`ADDR_W-1:0] off_ts;
	wire               aligned;
	wire               hit_gt;
	wire               hit_gs;
	wire               hit_chg;
	wire               hit_pub;
	wire               hit_ts;
	wire               hit_channel_enable_reg;
	wire               hit_set;
	wire               hit_clr;
	wire [2:0]         grp_n;
	wire [3:0]         gs_n;
	wire [2:0]         chg_n;
	wire [2:0]         pub_n;
	wire [2:0]         ts_n;

	// Offsets within each register window
	assign off_gt  = addr - `OFS_GRP_TASK;
	assign off_gs  = addr - `OFS_GRP_SUB;
	assign off_chg = addr - `OFS_CHG;
	assign off_pub = addr - `OFS_PUB;
	assign off_ts  = addr - `OFS_TSUB;
	assign aligned = (addr[1:0] == 2'h0);

	// Window hits; words outside every window read zero
	assign hit_gt   = aligned && addr >= `OFS_GRP_TASK &&
	                  off_gt < `SPAN_GRP;
	assign hit_gs   = aligned && addr >= `OFS_GRP_SUB &&
	                  off_gs < `SPAN_GRP;
	assign hit_chg  = aligned && addr >= `OFS_CHG &&
	                  off_chg < `SPAN_CHG;
	assign hit_pub  = aligned && addr >= `OFS_PUB &&
	                  off_pub < `SPAN_PUB;
	assign hit_ts   = aligned && addr >= `OFS_TSUB &&
	                  off_ts < `SPAN_TSUB;
	assign hit_channel_enable_reg = (addr == `OFS_CHANNEL_ENABLE_REG);
	assign hit_set  = (addr == `OFS_CHANNEL_ENABLE_REG_SET);
	assign hit_clr  = (addr == `OFS_CHANNEL_ENABLE_REG_CLR);

	// Entry indices; group tasks take two words per group, group members one
	assign grp_n = off_gt[5:3];
	assign gs_n  = off_gs[5:2];
	assign chg_n = off_chg[4:2];
	assign pub_n = off_pub[4:2];
	assign ts_n  = off_ts[4:2];

	// ------------------------------------------------------------
	// Publish and subscribe settings
	// ------------------------------------------------------------
	genvar gi;

	generate
		// One publish setting per event
		for (gi = 0; gi < `NUM_EVT; gi = gi + 1) begin : g_pub
			always @(posedge sys_clk) begin
				if (rst)
					pub_q[gi] <= `RST_CFG;
				else if (wr && hit_pub && pub_n == gi)
					pub_q[gi] <= {wdata[`CFG_EN_BIT],
					              wdata[`IDX_W-1:0]};
			end
			assign pub_flat[gi*`CFG_W +: `CFG_W] = pub_q[gi];
		end

		// One subscribe setting per task
		for (gi = 0; gi < `NUM_TSK; gi = gi + 1) begin : g_tsub
			always @(posedge sys_clk) begin
				if (rst)
					tsub_q[gi] <= `RST_CFG;
				else if (wr && hit_ts && ts_n == gi)
					tsub_q[gi] <= {wdata[`CFG_EN_BIT],
					               wdata[`IDX_W-1:0]};
			end
			assign tsub_flat[gi*`CFG_W +: `CFG_W] = tsub_q[gi];
		end

		// Even entries subscribe group enable, odd group disable
		for (gi = 0; gi < `NUM_GSUB; gi = gi + 1) begin : g_gsub
			always @(posedge sys_clk) begin
				if (rst)
					gsub_q[gi] <= `RST_CFG;
				else if (wr && hit_gs && gs_n == gi)
					gsub_q[gi] <= {wdata[`CFG_EN_BIT],
					               wdata[`IDX_W-1:0]};
			end
			assign gsub_flat[gi*`CFG_W +: `CFG_W] = gsub_q[gi];
		end

		// Group members; frozen while either group task listens
		for (gi = 0; gi < `NUM_GRP; gi = gi + 1) begin : g_chg
			wire locked;
			assign locked = gsub_q[2*gi][`CFG_EN_LOC] ||
			                gsub_q[2*gi+1][`CFG_EN_LOC];
			always @(posedge sys_clk) begin
				if (rst)
					channel_group_members_q[gi] <= `RST_CHG;
				else if (wr && hit_chg && chg_n == gi && !locked)
					channel_group_members_q[gi] <= wdata[`NUM_CH-1:0];
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// Channel routing
	// ------------------------------------------------------------
	evt_publish u_pub (
		.evt_in   (evt_in),
		.pub_cfg  (pub_flat),
		.chan_raw (chan_raw)
	);

	// Globally disabled channels carry nothing
	assign chan_live = chan_raw & channel_enable_reg_q;

	task_subscribe #(
		.NT (`NUM_TSK)
	) u_tsub (
		.chan    (chan_live),
		.sub_cfg (tsub_flat),
		.hit     (tsub_hit)
	);

	// Group tasks listen to channels like any task
	task_subscribe #(
		.NT (`NUM_GSUB)
	) u_gsub (
		.chan    (chan_live),
		.sub_cfg (gsub_flat),
		.hit     (gsub_hit)
	);

	// ------------------------------------------------------------
	// Group task triggers and channel enable update
	// ------------------------------------------------------------
	reg [`NUM_GRP-1:0] grp_en_trig;
	reg [`NUM_GRP-1:0] grp_dis_trig;
	reg [`NUM_CH-1:0]  en_mask;
	reg [`NUM_CH-1:0]  dis_mask;
	reg [`NUM_CH-1:0]  channel_enable_reg_base;
	integer g;
	integer h;

	// Software task write or subscribed channel pulse
	always @* begin
		grp_en_trig = {`NUM_GRP{1'h0}};
		grp_dis_trig = {`NUM_GRP{1'h0}};
		for (g = 0; g < `NUM_GRP; g = g + 1) begin
			grp_en_trig[g] = gsub_hit[2*g] ||
			                 (wr && hit_gt && grp_n == g &&
			                  !off_gt[2] && wdata[`TASK_GO_BIT]);
			grp_dis_trig[g] = gsub_hit[2*g+1] ||
			                  (wr && hit_gt && grp_n == g &&
			                   off_gt[2] && wdata[`TASK_GO_BIT]);
		end
	end

	// Gather member channels hit by enable and disable tasks
	always @* begin
		en_mask = {`NUM_CH{1'h0}};
		dis_mask = {`NUM_CH{1'h0}};
		for (h = 0; h < `NUM_GRP; h = h + 1) begin
			en_mask = en_mask | ({`NUM_CH{grp_en_trig[h]}} &
			          channel_group_members_q[h]);
			dis_mask = dis_mask | ({`NUM_CH{grp_dis_trig[h]}} &
			           channel_group_members_q[h]);
		end
		if (wr && hit_set)
			en_mask = en_mask | wdata[`NUM_CH-1:0];
		if (wr && hit_clr)
			dis_mask = dis_mask | wdata[`NUM_CH-1:0];
	end

	// Direct write first, then disables, enables applied last
	always @* begin
		channel_enable_reg_base = channel_enable_reg_q;
		if (wr && hit_channel_enable_reg)
			channel_enable_reg_base = wdata[`NUM_CH-1:0];
		channel_enable_reg_d = (channel_enable_reg_base & ~dis_mask) |
		                       en_mask;
	end

	// Global channel enables
	always @(posedge sys_clk) begin
		if (rst)
			channel_enable_reg_q <= `RST_CHANNEL_ENABLE_REG;
		else
			channel_enable_reg_q <= channel_enable_reg_d;
	end

	// ------------------------------------------------------------
	// Task and channel outputs
	// ------------------------------------------------------------
	always @(posedge sys_clk) begin
		if (rst) begin
			task_q       <= {`NUM_TSK{1'h0}};
			chan_pulse_q <= {`NUM_CH{1'h0}};
		end else begin
			task_q       <= tsub_hit;
			chan_pulse_q <= chan_live;
		end
	end

	assign task_out   = task_q;
	assign chan_pulse = chan_pulse_q;

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	always @* begin
		rdata_d = `RST_RDATA;
		if (hit_channel_enable_reg || hit_set || hit_clr)
			rdata_d[`NUM_CH-1:0] = channel_enable_reg_q;
		else if (hit_chg && chg_n < `NUM_GRP)
			rdata_d[`NUM_CH-1:0] = channel_group_members_q[chg_n];
		else if (hit_gs) begin
			rdata_d[`CFG_EN_BIT] = gsub_q[gs_n][`CFG_EN_LOC];
			rdata_d[`IDX_W-1:0]  = gsub_q[gs_n][`IDX_W-1:0];
		end else if (hit_pub) begin
			rdata_d[`CFG_EN_BIT] = pub_q[pub_n][`CFG_EN_LOC];
			rdata_d[`IDX_W-1:0]  = pub_q[pub_n][`IDX_W-1:0];
		end else if (hit_ts) begin
			rdata_d[`CFG_EN_BIT] = tsub_q[ts_n][`CFG_EN_LOC];
			rdata_d[`IDX_W-1:0]  = tsub_q[ts_n][`IDX_W-1:0];
		end
	end

	// Read data stands only in the cycle after the strobe
	always @(posedge sys_clk) begin
		if (rst)
			rdata_q <= `RST_RDATA;
		else if (rd)
			rdata_q <= rdata_d;
		else
			rdata_q <= `RST_RDATA;
	end

	assign rdata = rdata_q;

endmodule

// ===== test/evt_ic_properties.sv
// Port-level checks on the event channel interconnect
`timescale 1ns/1ps
module evt_ic_properties (
	input wire        sys_clk,
	input wire        rst,
	input wire [11:0] addr,
	input wire [31:0] wdata,
	input wire        wr,
	input wire        rd,
	input wire [31:0] rdata,
	input wire [7:0]  evt_in,
	input wire [7:0]  task_out,
	input wire [15:0] chan_pulse
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	// ------------------------------------------------------------
	// Sequences
	// ------------------------------------------------------------
	// Write to register a, read register b (which may be the same) in the next cycle
	sequence s_wr_rd(a, b);
		wr && addr == a ##1 rd && addr == b;
	endsequence

	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	property p_rd_idle;
		!$past(rd) |-> rdata == 32'h0;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data outside read cycle");

	property p_chan_cause;
		chan_pulse != 16'h0 |-> $past(evt_in) != 8'h00;
	endproperty
	a_chan_cause: assert property (p_chan_cause)
		else $error("channel pulse without event");

	property p_task_chan;
		task_out != 8'h00 |-> chan_pulse != 16'h0;
	endproperty
	a_task_chan: assert property (p_task_chan)
		else $error("task without channel pulse");

	property p_set;
		s_wr_rd(12'h504, 12'h500) |=> (rdata[15:0] &
			$past(wdata[15:0], 2)) == $past(wdata[15:0], 2);
	endproperty
	a_set: assert property (p_set)
		else $error("set write did not enable");

	property p_clr;
		s_wr_rd(12'h508, 12'h500) |=>
			(rdata[15:0] & $past(wdata[15:0], 2)) == 16'h0;
	endproperty
	a_clr: assert property (p_clr)
		else $error("clear write did not disable");

	property p_mirror;
		s_wr_rd(12'h500, 12'h504) |=>
			rdata == {16'h0, $past(wdata[15:0], 2)};
	endproperty
	a_mirror: assert property (p_mirror)
		else $error("set register read differs");

	property p_setting;
		s_wr_rd(12'ha00, 12'ha00) |=>
			rdata == ($past(wdata, 2) & 32'h8000_00ff);
	endproperty
	a_setting: assert property (p_setting)
		else $error("setting layout wrong");

	property p_zero_rd;
		rd && (addr < 12'h080 || addr == 12'hffc) |=> rdata == 32'h0;
	endproperty
	a_zero_rd: assert property (p_zero_rd)
		else $error("task or unmapped read not zero");
endmodule

// ===== test/evt_periph_model.sv
// Peripheral side: turns bench requests into event pulses
`timescale 1ns/1ps
module evt_periph_model (
	input  wire       sys_clk,
	input  wire       rst,
	input  wire [7:0] fire,
	output reg  [7:0] evt_in
);
	// One event line per peripheral event, one cycle per request
	always @(posedge sys_clk) begin
		evt_in <= rst ? 8'h00 : fire;
	end
endmodule

// ===== test/event_channel_interconnect_bench.sv
// Self-checking bench for the event channel interconnect
`timescale 1ns/1ps
module event_channel_interconnect_bench;
	reg         sys_clk   = 1'b0;
	reg         rst       = 1'b1;
	reg  [11:0] addr      = 12'h000;
	reg  [31:0] wdata     = 32'h0;
	reg         wr        = 1'b0;
	reg         rd        = 1'b0;
	reg  [7:0]  fire      = 8'h00;
	wire [31:0] rdata;
	wire [7:0]  evt_in;
	wire [7:0]  task_out;
	wire [15:0] chan_pulse;
	integer     bad_count = 0;
	integer     compares  = 0;

	// Clock generation
	always #50 sys_clk = ~sys_clk;

	evt_interconnect evt_interconnect_inst (.sys_clk(sys_clk), .rst(rst),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.evt_in(evt_in), .task_out(task_out), .chan_pulse(chan_pulse));
	evt_periph_model evt_periph_model_inst (.sys_clk(sys_clk),
		.rst(rst), .fire(fire), .evt_in(evt_in));

	// Verdict and end of run
	task final_report;
		begin
			if (bad_count == 0 && compares > 0)
				$display("TB: PASS");
			else
				$display("TB: FAIL");
			$finish;
		end
	endtask

	// One comparison
	task check(input ok, input [8*12:1] msg);
		begin
			compares = compares + 1;
			if (!ok) begin
				bad_count = bad_count + 1;
				$display("mismatch at %0t: %0s", $time, msg);
			end
		end
	endtask

	// Bus write; the strobe stays high until rd_chk or pulse lowers it
	task wr_reg(input [11:0] a, input [31:0] d);
		begin
			@(posedge sys_clk);
			wr <= 1'b1;
			rd <= 1'b0;
			addr <= a;
			wdata <= d;
		end
	endtask

	// Bus read, data judged in the cycle after the strobe
	task rd_chk(input [11:0] a, input [31:0] e, input [8*12:1] m);
		begin
			@(posedge sys_clk);
			wr <= 1'b0;
			rd <= 1'b1;
			addr <= a;
			@(posedge sys_clk);
			rd <= 1'b0;
			#1 check(rdata === e, m);
		end
	endtask

	// Raise events, judge channel and task pulses two cycles later
	task pulse(input [7:0] ev, input [15:0] ec, input [7:0] et,
		input [8*12:1] m);
		begin
			@(posedge sys_clk);
			wr <= 1'b0;
			fire <= ev;
			@(posedge sys_clk);
			fire <= 8'h00;
			@(posedge sys_clk);
			#1 check(chan_pulse === ec && task_out === et, m);
		end
	endtask

	// Reset values and channel register access
	task t_regs;
		begin
			rd_chk(12'h500, 32'h0, "channel_enable_reg reset");
			rd_chk(12'ha00, 32'h0, "tsub reset");
			wr_reg(12'ha00, 32'hffff_ff02);
			rd_chk(12'ha00, 32'h8000_0002, "sub layout");
			wr_reg(12'h500, 32'h0000_00f0);
			rd_chk(12'h504, 32'h0000_00f0, "set reads");
			rd_chk(12'h508, 32'h0000_00f0, "clr reads");
			wr_reg(12'h504, 32'h0000_000f);
			rd_chk(12'h500, 32'h0000_00ff, "set ones");
			wr_reg(12'h508, 32'h0000_00f0);
			rd_chk(12'h500, 32'h0000_000f, "clr ones");
			rd_chk(12'hffc, 32'h0, "unmapped");
			rd_chk(12'h000, 32'h0, "task word");
		end
	endtask

	// Publish and subscribe routing
	task t_route;
		begin
			wr_reg(12'h900, 32'h8000_0002);
			wr_reg(12'h904, 32'h8000_0002);
			wr_reg(12'h908, 32'h0000_0003);
			wr_reg(12'ha04, 32'h8000_0002);
			wr_reg(12'ha08, 32'h8000_0003);
			wr_reg(12'ha0c, 32'h0000_0002);
			pulse(8'h03, 16'h0004, 8'h03, "merge");
			pulse(8'h02, 16'h0004, 8'h03, "one event");
			pulse(8'h04, 16'h0000, 8'h00, "pub off");
			wr_reg(12'h908, 32'h8000_0003);
			pulse(8'h04, 16'h0008, 8'h04, "ch3");
			wr_reg(12'h508, 32'h0000_0004);
			pulse(8'h01, 16'h0000, 8'h00, "ch off");
		end
	endtask

	// Channel groups and their tasks
	task t_group;
		begin
			wr_reg(12'h800, 32'h0000_0004);
			wr_reg(12'h084, 32'h8000_0002);
			wr_reg(12'h800, 32'h0000_0008);
			rd_chk(12'h800, 32'h0000_0004, "locked");
			wr_reg(12'h504, 32'h0000_0004);
			pulse(8'h01, 16'h0004, 8'h03, "shot");
			rd_chk(12'h500, 32'h0000_000b, "shot off");
			pulse(8'h01, 16'h0000, 8'h00, "shot gone");
			wr_reg(12'h084, 32'h0);
			wr_reg(12'h000, 32'h0000_0001);
			rd_chk(12'h500, 32'h0000_000f, "grp en");
			wr_reg(12'h004, 32'h0000_0001);
			rd_chk(12'h500, 32'h0000_000b, "grp dis");
			wr_reg(12'h804, 32'h0000_0004);
			wr_reg(12'h080, 32'h8000_0003);
			wr_reg(12'h08c, 32'h8000_0003);
			pulse(8'h04, 16'h0008, 8'h04, "both");
			rd_chk(12'h500, 32'h0000_000f, "en wins");
		end
	endtask

	// Main sequence
	initial begin
		repeat (8) @(posedge sys_clk);
		rst <= 1'b0;
		t_regs;
		t_route;
		t_group;
		final_report;
	end

	// Watchdog against a hang
	initial begin
		#1_000_000;
		bad_count = bad_count + 1;
		final_report;
	end
endmodule

bind evt_interconnect evt_ic_properties evt_ic_properties_inst (
	.sys_clk(sys_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
	.rd(rd), .rdata(rdata), .evt_in(evt_in), .task_out(task_out),
	.chan_pulse(chan_pulse));
